// ---- core/car_pkg.sv ----
// package: register map, field layout, range constants and carrier types for the alarm/range block
package car_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL    = 8'h00; // range mode, manual range, auto application
	localparam logic [7:0] OFS_FIRST_CFG  = 8'h04; // first_conc_alarm configuration
	localparam logic [7:0] OFS_FIRST_SET  = 8'h08; // first_conc_alarm setpoint
	localparam logic [7:0] OFS_SECOND_CFG = 8'h0c; // second_conc_alarm configuration
	localparam logic [7:0] OFS_SECOND_SET = 8'h10; // second_conc_alarm setpoint
	localparam logic [7:0] OFS_PWCTL   = 8'h14; // password enable / entry
	localparam logic [7:0] OFS_STATUS  = 8'h18; // live state (read only)
	localparam logic [7:0] OFS_RNG0    = 8'h20; // ranges 0..4: lo[15:0] hi[31:16]
	localparam logic [7:0] OFS_APP     = 8'h34; // application of ranges 0..3, 3 bits each
	localparam logic [7:0] OFS_CONC    = 8'h38; // last sample, not clamped
	// alarm config fields
	localparam int ACF_DIRHI  = 0; // trip_above_setpoint when 1, else trip_beneath_setpoint
	localparam int ACF_DEFEAT = 1;
	localparam int ACF_DEENRG = 2; // relay_deenergize_on_trip
	localparam int ACF_LATCH  = 3;
	localparam int ACF_PPM    = 4; // setpoint unit: 1 = ppm, 0 = percent
	// control fields
	localparam int CTL_AUTO  = 0;
	localparam int CTL_MRNG  = 4; // [6:4] manual range index
	localparam int CTL_APP   = 8; // [10:8] auto application
	localparam int PW_ENABLE = 0;
	// range constants
	localparam int           NUM_RNG    = 5;   // index 4 reserved
	localparam logic [2:0]   RNG_MAXUSE = 3'h3;
	localparam logic [7:0]   DOWN_PCT   = 8'h55; // 85 percent
	localparam logic [15:0]  PPM_PER_PCT = 16'h2710; // 10000 ppm per percent
	localparam logic [15:0]  DAC_FULL   = 16'hffff; // full scale = 1 V dc / 20 mA
	localparam logic [31:0]  PW_RESET   = 32'h00000000; // password value, arbitrary
	// reset values
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [4:0]  ACFG_RST = 5'h01;
	localparam logic [15:0] RHI_RST  = 16'h0064;
	localparam logic [11:0] APP_RST  = 12'h000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one alarm's settings
	typedef struct packed {
		logic [4:0]  cfg;
		logic [15:0] setp;
	} car_alarm_t;

	// one range's limits (in ppm, same scale as the sample)
	typedef struct packed {
		logic [15:0] hi;
		logic [15:0] lo;
	} car_range_t;
endpackage

// ---- core/car_core.sv ----
// concentration alarm and range selection block with an AXI4-Lite register slave
// Operation
// RULE1 - high alarm trips above setpoint
// RULE2 - low alarm trips beneath setpoint
// RULE3 - failsafe: relay de-energized while tripped
// RULE4 - non-failsafe: relay energized while tripped
// RULE5 - latching alarm holds after recovery
// RULE6 - latched alarm clears only by operator
// RULE7 - non-latching alarm clears on recovery
// RULE8 - defeat suppresses alarm activation
// RULE9 - defeat or latch toggle clears latch
// RULE10 - two alarms, each fully independent settings
// RULE11 - setpoint unit percent or ppm
// RULE12 - password locks alarm configuration
// RULE13 - manual mode: fixed range 00 to 03
// RULE14 - manual range limits separately editable
// RULE15 - distinct applications force manual mode
// RULE16 - auto mode queues application's ranges
// RULE17 - upper limit reached: go up
// RULE18 - below 85 percent lower scale: down
// RULE19 - range change drives ID and rescale
// RULE20 - fixed range clamps analog at full
// RULE21 - digital report is never clamped
// RULE22 - decisions re-evaluated each valid sample
// RULE23 - defeated relay keeps non-alarm polarity
`timescale 1ns/1ns
module car_core (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// concentration sample, same clock domain
	input  wire logic [15:0] concData,
	input  wire logic        concValid,
	// far side: relays, range ID, analog output, readout
	output logic [1:0]       relayOn,
	output logic [1:0]       alarmActive,
	output logic [2:0]       rangeId,
	output logic [15:0]      analogOut,
	output logic [15:0]      readout
);
	// whole module state
	typedef struct packed {
		logic                awHeld, wHeld, bv, rv;
		logic [7:0]          awA;
		logic [31:0]         wD;
		logic [3:0]          wS;           // write strobes taken with the data
		logic                awRdy, wRdy, arRdy; // ready lines, registered
		logic [31:0]         rD;
		logic [1:0]          bR, rR;
		logic [31:0]         ctrl;
		car_pkg::car_alarm_t [1:0] al;
		car_pkg::car_range_t [4:0] rng;
		logic [11:0]         app;
		logic                pwOn, unlocked;
		logic [1:0]          act;
		logic [1:0]          relay;
		logic [2:0]          cur;
		logic [15:0]         aout;
		logic [15:0]         conc;
	} car_state_t;

	car_state_t st;      // registered state
	car_state_t next_st; // next state

	logic [31:0] setpPpm    [2]; // each alarm's setpoint expressed in ppm
	logic        autoOk;         // auto mode allowed
	logic        wrFire;         // write address and data both held
	logic [2:0]  upNext, dnNext; // neighbour ranges within the application
	logic        upFound, dnFound;
	logic [31:0] dnLim;

	// samples are in ppm; a percent setpoint is scaled up instead of dividing the
	// sample down, so a fraction of a percent above the setpoint still trips
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (st.al[i].cfg[car_pkg::ACF_PPM])
				setpPpm[i] = 32'(st.al[i].setp);
			else
				setpPpm[i] = 32'(st.al[i].setp) * 32'(car_pkg::PPM_PER_PCT); // see RULE11
		end
	end

	// auto mode needs two usable ranges sharing any one application, not only the chosen one
	always_comb begin
		int n;
		n = 0;
		for (int r = 0; r < 3; r++) begin
			for (int q = r + 1; q < 4; q++) begin
				if (st.app[r*3 +: 3] == st.app[q*3 +: 3])
					n = n + 1;
			end
		end
		autoOk = (n != 0); // see RULE15
	end

	// nearest higher and lower range of the same application
	always_comb begin
		logic [2:0] a;
		a = st.ctrl[car_pkg::CTL_APP +: 3];
		upNext = st.cur;
		dnNext = st.cur;
		upFound = 1'b0;
		dnFound = 1'b0;
		for (int r = 3; r >= 0; r--) begin
			if (r > int'(st.cur) && st.app[r*3 +: 3] == a) begin
				upNext = 3'(r); // see RULE16
				upFound = 1'b1;
			end
		end
		for (int r = 0; r < 4; r++) begin
			if (r < int'(st.cur) && st.app[r*3 +: 3] == a) begin
				dnNext = 3'(r);
				dnFound = 1'b1;
			end
		end
		dnLim = (32'(st.rng[dnNext].hi) * 32'(car_pkg::DOWN_PCT)) / 32'd100; // see RULE18
	end

	assign wrFire = st.awHeld && st.wHeld && !st.bv;

	// next-state logic: bus, configuration, alarms, ranging
	always_comb begin
		logic [7:0]  a;
		logic        cfgOk;
		logic        trip;
		logic [31:0] span;
		logic [31:0] scaled;
		logic [4:0]  oldCfg;
		next_st = st;
		a = st.awA;
		cfgOk = !st.pwOn || st.unlocked; // see RULE12
		trip = 1'b0;
		span = 32'h0;
		scaled = 32'h0;
		oldCfg = 5'h0;
		// write channels taken independently
		if (s_awvalid && !st.awHeld) begin
			next_st.awHeld = 1'b1;
			next_st.awA = s_awaddr;
		end
		if (s_wvalid && !st.wHeld) begin
			next_st.wHeld = 1'b1;
			next_st.wD = s_wdata;
			next_st.wS = s_wstrb;
		end
		if (st.bv && s_bready)
			next_st.bv = 1'b0;
		if (st.rv && s_rready)
			next_st.rv = 1'b0;
		// register write decode
		if (wrFire) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bv = 1'b1;
			next_st.bR = car_pkg::RESP_OKAY;
			if (a == car_pkg::OFS_CTRL) begin
				next_st.ctrl = st.wD;
				if (st.wD[car_pkg::CTL_MRNG +: 3] > car_pkg::RNG_MAXUSE)
					next_st.ctrl[car_pkg::CTL_MRNG +: 3] = st.ctrl[car_pkg::CTL_MRNG +: 3]; // see RULE13
			end else if (a == car_pkg::OFS_FIRST_CFG || a == car_pkg::OFS_SECOND_CFG) begin
				if (cfgOk) begin
					for (int i = 0; i < 2; i++) begin
						if (a == (i == 0 ? car_pkg::OFS_FIRST_CFG : car_pkg::OFS_SECOND_CFG))
							next_st.al[i].cfg = st.wD[4:0]; // see RULE10
					end
				end else begin
					next_st.bR = car_pkg::RESP_SLVERR;
				end
			end else if (a == car_pkg::OFS_FIRST_SET || a == car_pkg::OFS_SECOND_SET) begin
				if (cfgOk) begin
					for (int i = 0; i < 2; i++) begin
						if (a == (i == 0 ? car_pkg::OFS_FIRST_SET : car_pkg::OFS_SECOND_SET))
							next_st.al[i].setp = st.wD[15:0];
					end
				end else begin
					next_st.bR = car_pkg::RESP_SLVERR;
				end
			end else if (a == car_pkg::OFS_PWCTL) begin
				// bit0 arms protection; a write of the password unlocks
				next_st.pwOn = st.wD[car_pkg::PW_ENABLE];
				next_st.unlocked = (st.wD[31:1] == car_pkg::PW_RESET[31:1]);
			end else if (a >= car_pkg::OFS_RNG0 && a < car_pkg::OFS_APP) begin
				// lower and upper halves written through byte strobes
				for (int b = 0; b < 4; b++) begin
					if (st.wS[b])
						next_st.rng[(a - car_pkg::OFS_RNG0) >> 2][b*8 +: 8] = st.wD[b*8 +: 8]; // see RULE14
				end
			end else if (a == car_pkg::OFS_APP) begin
				next_st.app = st.wD[11:0];
			end else if (a != car_pkg::OFS_STATUS && a != car_pkg::OFS_CONC) begin
				next_st.bR = car_pkg::RESP_SLVERR;
			end
		end
		// read decode
		if (s_arvalid && !st.rv) begin
			next_st.rv = 1'b1;
			next_st.rR = car_pkg::RESP_OKAY;
			next_st.rD = 32'h0;
			if (s_araddr == car_pkg::OFS_CTRL)
				next_st.rD = st.ctrl;
			else if (s_araddr == car_pkg::OFS_FIRST_CFG)
				next_st.rD = {27'h0, st.al[0].cfg};
			else if (s_araddr == car_pkg::OFS_FIRST_SET)
				next_st.rD = {16'h0, st.al[0].setp};
			else if (s_araddr == car_pkg::OFS_SECOND_CFG)
				next_st.rD = {27'h0, st.al[1].cfg};
			else if (s_araddr == car_pkg::OFS_SECOND_SET)
				next_st.rD = {16'h0, st.al[1].setp};
			else if (s_araddr == car_pkg::OFS_PWCTL)
				next_st.rD = {30'h0, st.unlocked, st.pwOn};
			else if (s_araddr == car_pkg::OFS_STATUS)
				next_st.rD = {24'h0, autoOk, st.cur, st.relay, st.act};
			else if (s_araddr >= car_pkg::OFS_RNG0 && s_araddr < car_pkg::OFS_APP)
				next_st.rD = st.rng[(s_araddr - car_pkg::OFS_RNG0) >> 2];
			else if (s_araddr == car_pkg::OFS_APP)
				next_st.rD = {20'h0, st.app};
			else if (s_araddr == car_pkg::OFS_CONC)
				next_st.rD = {16'h0, st.conc};
			else
				next_st.rR = car_pkg::RESP_SLVERR;
		end
		// alarm evaluation per sample; latch clearing on config toggles
		for (int i = 0; i < 2; i++) begin
			oldCfg = st.al[i].cfg;
			if (st.al[i].cfg[car_pkg::ACF_DIRHI])
				trip = 32'(concData) > setpPpm[i]; // see RULE1
			else
				trip = 32'(concData) < setpPpm[i]; // see RULE2
			// defeat on->off or latch off->on acknowledges; setting defeat also clears a latch
			if ((oldCfg[car_pkg::ACF_DEFEAT] && !next_st.al[i].cfg[car_pkg::ACF_DEFEAT]) ||
			    (!oldCfg[car_pkg::ACF_LATCH] && next_st.al[i].cfg[car_pkg::ACF_LATCH]))
				next_st.act[i] = 1'b0; // see RULE9 see RULE6
			// a sample in a latch off->on acknowledge cycle wins; in a defeat on->off cycle its trip is dropped
			if (concValid) begin // see RULE22
				if (st.al[i].cfg[car_pkg::ACF_DEFEAT])
					next_st.act[i] = 1'b0; // see RULE8
				else if (st.al[i].cfg[car_pkg::ACF_LATCH])
					next_st.act[i] = next_st.act[i] | trip; // see RULE5
				else
					next_st.act[i] = trip; // see RULE7
			end
			if (next_st.al[i].cfg[car_pkg::ACF_DEFEAT])
				next_st.act[i] = 1'b0; // see RULE23
			// relay polarity follows failsafe
			if (next_st.al[i].cfg[car_pkg::ACF_DEENRG])
				next_st.relay[i] = !next_st.act[i]; // see RULE3
			else
				next_st.relay[i] = next_st.act[i]; // see RULE4
		end
		// range selection
		if (!st.ctrl[car_pkg::CTL_AUTO] || !autoOk) begin
			next_st.cur = st.ctrl[car_pkg::CTL_MRNG +: 3]; // see RULE13
		end else if (concValid) begin
			if (upFound && concData >= st.rng[st.cur].hi)
				next_st.cur = upNext; // see RULE17
			else if (dnFound && 32'(concData) < dnLim)
				next_st.cur = dnNext; // see RULE18
		end
		// analog output scaled to the active range, saturating at full scale
		if (concValid) begin
			next_st.conc = concData; // see RULE21
			span = 32'(st.rng[st.cur].hi) - 32'(st.rng[st.cur].lo);
			if (concData >= st.rng[st.cur].hi || span == 32'h0)
				next_st.aout = car_pkg::DAC_FULL; // see RULE20
			else if (concData <= st.rng[st.cur].lo)
				next_st.aout = 16'h0;
			else begin
				scaled = ((32'(concData) - 32'(st.rng[st.cur].lo)) * 32'(car_pkg::DAC_FULL)) / span;
				next_st.aout = scaled[15:0]; // see RULE19
			end
		end
		// ready lines registered so the bus sees them straight from flip-flops
		next_st.awRdy = !next_st.awHeld;
		next_st.wRdy = !next_st.wHeld;
		next_st.arRdy = !next_st.rv;
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			st <= '0;
			st.ctrl <= car_pkg::CTRL_RST;
			st.app <= car_pkg::APP_RST;
			st.awRdy <= 1'b1;
			st.wRdy <= 1'b1;
			st.arRdy <= 1'b1;
			for (int i = 0; i < 2; i++) begin
				st.al[i].cfg <= car_pkg::ACFG_RST;
				st.relay[i] <= 1'b0;
			end
			for (int r = 0; r < car_pkg::NUM_RNG; r++)
				st.rng[r].hi <= car_pkg::RHI_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from flip-flops
	assign s_awready   = st.awRdy;
	assign s_wready    = st.wRdy;
	assign s_bvalid    = st.bv;
	assign s_bresp     = st.bR;
	assign s_arready   = st.arRdy;
	assign s_rvalid    = st.rv;
	assign s_rdata     = st.rD;
	assign s_rresp     = st.rR;
	assign relayOn     = st.relay;
	assign alarmActive = st.act;
	assign rangeId     = st.cur;
	assign analogOut   = st.aout;
	assign readout     = st.conc;

	// assertions
	property p_relay_pol;
		@(posedge clk) disable iff (srst)
		st.al[0].cfg[car_pkg::ACF_DEENRG] |-> relayOn[0] != alarmActive[0];
	endproperty
	a_relay_pol: assert property (p_relay_pol) else $error("failsafe relay polarity wrong"); // see RULE3
	property p_relay_nfs;
		@(posedge clk) disable iff (srst)
		!st.al[1].cfg[car_pkg::ACF_DEENRG] |-> relayOn[1] == alarmActive[1];
	endproperty
	a_relay_nfs: assert property (p_relay_nfs) else $error("non-failsafe relay wrong"); // see RULE4
	property p_defeat;
		@(posedge clk) disable iff (srst)
		st.al[0].cfg[car_pkg::ACF_DEFEAT] |-> !alarmActive[0];
	endproperty
	a_defeat: assert property (p_defeat) else $error("defeated alarm active"); // see RULE8
	property p_hi_trip;
		@(posedge clk) disable iff (srst)
		concValid && !st.al[0].cfg[car_pkg::ACF_DEFEAT] && st.al[0].cfg[car_pkg::ACF_DIRHI]
			&& 32'(concData) > setpPpm[0] && !wrFire |=> alarmActive[0];
	endproperty
	a_hi_trip: assert property (p_hi_trip) else $error("high alarm missed"); // see RULE1
	property p_lo_trip;
		@(posedge clk) disable iff (srst)
		concValid && !st.al[1].cfg[car_pkg::ACF_DEFEAT] && !st.al[1].cfg[car_pkg::ACF_DIRHI]
			&& 32'(concData) < setpPpm[1] && !wrFire |=> alarmActive[1];
	endproperty
	a_lo_trip: assert property (p_lo_trip) else $error("low alarm missed"); // see RULE2
	property p_latch_hold;
		@(posedge clk) disable iff (srst)
		alarmActive[0] && st.al[0].cfg[car_pkg::ACF_LATCH] && !wrFire |=> alarmActive[0];
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch dropped"); // see RULE5
	property p_manual_rng;
		@(posedge clk) disable iff (srst)
		!st.ctrl[car_pkg::CTL_AUTO] |=> ##1 rangeId <= car_pkg::RNG_MAXUSE;
	endproperty
	a_manual_rng: assert property (p_manual_rng) else $error("manual range out of set"); // see RULE13
	property p_clamp;
		@(posedge clk) disable iff (srst)
		concValid && concData >= st.rng[st.cur].hi |=> analogOut == car_pkg::DAC_FULL;
	endproperty
	a_clamp: assert property (p_clamp) else $error("analog not clamped"); // see RULE20
	property p_readout;
		@(posedge clk) disable iff (srst)
		concValid |=> readout == $past(concData);
	endproperty
	a_readout: assert property (p_readout) else $error("readout not raw"); // see RULE21
	c_trip: cover property (@(posedge clk) disable iff (srst) $rose(alarmActive[0]));
	c_up: cover property (@(posedge clk) disable iff (srst) rangeId > $past(rangeId));
	c_down: cover property (@(posedge clk) disable iff (srst) rangeId < $past(rangeId));
	c_wr: cover property (@(posedge clk) disable iff (srst) s_bvalid && s_bready);
endmodule // car_core

// ---- verif/car_relay_model.sv ----
// far-side model: relay contacts and dc output seen by the plant wiring
`timescale 1ns/1ns
module car_relay_model (
	// clock
	input  wire logic        clk,
	// coil drive and dc level from the block
	input  wire logic [1:0]  relayOn,
	input  wire logic [15:0] analogOut,
	// contact state and dc level at the terminals
	output logic [1:0]       contact,
	output logic [15:0]      dcLevel
);
	// normally-open contacts close with the coil; no bounce is modelled,
	// so the bench may read the contact in the same cycle as the coil
	assign contact = relayOn;
	// the output stage follows the code; saturation is done upstream
	always_ff @(posedge clk) begin
		dcLevel <= analogOut;
	end
endmodule // car_relay_model

// ---- verif/car_core_test.sv ----
// self-checking bench for the alarm and range block
`timescale 1ns/1ns
module car_core_test;
	logic        clk;                        // 50 MHz system clock
	logic        srst;                       // synchronous reset
	logic [7:0]  awaddr, araddr;             // bus addresses
	logic [31:0] wdata, rdata, rd;           // bus data, last read
	logic        awvalid, wvalid, bready;    // write side requests
	logic        arvalid, rready;            // read side requests
	logic        awready, wready, bvalid;    // write side answers
	logic        arready, rvalid;            // read side answers
	logic [1:0]  bresp, rresp, resp;         // responses, last one
	logic [15:0] concData, analogOut, readout, dcLevel;
	logic        concValid;                  // sample strobe
	logic [1:0]  relayOn, alarmActive, contact, a1, a2;
	logic [2:0]  rangeId, hs;                // range, handshake view
	int          n_errors, checks;
	assign hs = {bvalid, rvalid, arready};
	assign a1 = {relayOn[0], alarmActive[0]}; // relay and state, first
	assign a2 = {relayOn[1], alarmActive[1]}; // relay and state, second

	car_core car_core_i (.clk(clk), .srst(srst), .s_awaddr(awaddr),
		.s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
		.s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
		.s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
		.concData(concData), .concValid(concValid), .relayOn(relayOn),
		.alarmActive(alarmActive), .rangeId(rangeId), .analogOut(analogOut),
		.readout(readout));
	car_relay_model car_relay_model_i (.clk(clk), .relayOn(relayOn),
		.analogOut(analogOut), .contact(contact), .dcLevel(dcLevel));

	// verdict and end of run
	task automatic summarize();
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// compare one value, count and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// bounded wait on one answer line, looked at mid-cycle
	task automatic waitHi(input int k);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > 200) begin
				n_errors++;
				summarize();
			end
		end while (hs[k] !== 1'b1);
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
		bit awDone, wDone;
		awDone = 0;
		wDone = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(awDone && wDone)) begin
			@(negedge clk);
			if (awready === 1'b1) awDone = 1;
			if (wready === 1'b1) wDone = 1;
			@(posedge clk);
			if (awDone) awvalid <= 1'b0;
			if (wDone) wvalid <= 1'b0;
		end
		bready <= 1'b1;
		waitHi(2);
		resp = bresp;
		@(posedge clk);
		bready <= 1'b0;
		@(negedge clk);
	endtask
	// read one word; rready is held until the answer
	task automatic axiRead(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		waitHi(0);
		@(posedge clk);
		arvalid <= 1'b0;
		waitHi(1);
		rd = rdata;
		resp = rresp;
		@(posedge clk);
		rready <= 1'b0;
		@(negedge clk);
	endtask
	// one sample pulse; outputs are read a cycle after the pulse edge
	task automatic sample(input logic [15:0] c);
		@(posedge clk);
		concData <= c;
		concValid <= 1'b1;
		@(posedge clk);
		concValid <= 1'b0;
		@(posedge clk);
		@(negedge clk);
	endtask

	// reset values and the unmapped hole
	task automatic tReset();
		axiRead(car_pkg::OFS_CTRL);
		check(rd, car_pkg::CTRL_RST);
		axiRead(car_pkg::OFS_FIRST_CFG);
		check(rd, 32'(car_pkg::ACFG_RST));
		axiRead(car_pkg::OFS_RNG0);
		check(32'(rd[31:16]), 32'(car_pkg::RHI_RST));
		check(32'({rangeId, alarmActive}), 32'h0);
		axiRead(8'h3c);
		check(32'(resp), 32'(car_pkg::RESP_SLVERR));
		axiWrite(8'h3c, 32'h0);
		check(32'(resp), 32'(car_pkg::RESP_SLVERR));
	endtask
	// high non-failsafe beside low failsafe, both non-latching
	task automatic tDirection();
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h11);
		axiWrite(car_pkg::OFS_FIRST_SET, 32'd500);
		axiWrite(car_pkg::OFS_SECOND_CFG, 32'h14);
		axiWrite(car_pkg::OFS_SECOND_SET, 32'd500);
		sample(16'd600);
		check(32'(a1), 32'h3);
		check(32'(a2), 32'h2);
		check(32'(contact), 32'h3);
		sample(16'd100);
		check(32'(a1), 32'h0);
		check(32'(a2), 32'h1);
	endtask
	// latch holds, defeat and latch toggles clear it
	task automatic tLatch();
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h19);
		sample(16'd600);
		sample(16'd100);
		check(32'(a1), 32'h3);
		sample(16'd100);
		check(32'(a1), 32'h3);
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h1b);
		check(32'(a1), 32'h0);
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h19);
		sample(16'd100);
		check(32'(a1), 32'h0);
		sample(16'd600);
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h11);
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h19);
		check(32'(a1), 32'h0);
		// defeated failsafe alarm keeps its coil energized
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h17);
		sample(16'd600);
		check(32'(a1), 32'h2);
	endtask
	// percent setpoint: one percent is ten thousand ppm
	task automatic tPercent();
		axiWrite(car_pkg::OFS_FIRST_CFG, 32'h01);
		axiWrite(car_pkg::OFS_FIRST_SET, 32'd1);
		sample(16'h2800);
		check(32'(a1), 32'h3);
		sample(16'h2000);
		check(32'(a1), 32'h0);
	endtask
	// armed lock refuses alarm settings until the password is given
	task automatic tLock();
		axiWrite(car_pkg::OFS_PWCTL, {~car_pkg::PW_RESET[31:1], 1'b1});
		axiWrite(car_pkg::OFS_FIRST_SET, 32'd777);
		check(32'(resp), 32'(car_pkg::RESP_SLVERR));
		axiRead(car_pkg::OFS_FIRST_SET);
		check(rd, 32'd1);
		axiWrite(car_pkg::OFS_PWCTL, {car_pkg::PW_RESET[31:1], 1'b1});
		axiWrite(car_pkg::OFS_FIRST_SET, 32'd777);
		check(32'(resp), 32'(car_pkg::RESP_OKAY));
		axiWrite(car_pkg::OFS_PWCTL, 32'h0);
	endtask
	// fixed range saturates the dc code but not the readout
	task automatic tClamp();
		axiWrite(car_pkg::OFS_RNG0, 32'h00640000);
		sample(16'd200);
		check(32'(analogOut), 32'(car_pkg::DAC_FULL));
		check(32'(dcLevel), 32'(car_pkg::DAC_FULL));
		check(32'(readout), 32'd200);
		sample(16'd0);
		check(32'(analogOut), 32'h0);
	endtask
	// one application over four ranges: up at the top, down below 85 percent
	task automatic tAuto();
		axiWrite(8'h24, 32'h03e80000);
		axiWrite(8'h28, 32'h27100000);
		axiWrite(8'h2c, 32'hea600000);
		axiWrite(car_pkg::OFS_APP, 32'h0);
		axiWrite(car_pkg::OFS_CTRL, 32'h1);
		sample(16'd50);
		check(32'(rangeId), 32'h0);
		sample(16'd100);
		check(32'(rangeId), 32'h1);
		sample(16'd90);
		check(32'(rangeId), 32'h1);
		sample(16'd80);
		check(32'(rangeId), 32'h0);
	endtask
	// manual index: reserved index four leaves the range alone
	task automatic tManual();
		axiWrite(car_pkg::OFS_CTRL, 32'h10);
		sample(16'd50);
		check(32'(rangeId), 32'h1);
		axiWrite(car_pkg::OFS_CTRL, 32'h40);
		sample(16'd50);
		check(32'(rangeId), 32'h1);
		axiWrite(car_pkg::OFS_CTRL, 32'h30);
		sample(16'd2000);
		check(32'(rangeId), 32'h3);
		// all ranges on different applications: auto request falls back to manual
		axiWrite(car_pkg::OFS_APP, 32'h688);
		axiWrite(car_pkg::OFS_CTRL, 32'h21);
		sample(16'd50);
		check(32'(rangeId), 32'h2);
		axiRead(car_pkg::OFS_STATUS);
		check(32'(rd[7]), 32'h0);
	endtask

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// main sequence
	initial begin
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, concValid} = '0;
		{awaddr, araddr, wdata, concData} = '0;
		n_errors = 0;
		checks = 0;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		@(negedge clk);
		tReset();
		tDirection();
		tLatch();
		tPercent();
		tLock();
		tClamp();
		tAuto();
		tManual();
		summarize();
	end
endmodule // car_core_test
